// ===== bench/flash_bus_properties.sv
`timescale 1ns/1ps
module flash_bus_properties import flash_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic byte_high_enable_n,
	input wire logic write_low_strobe_n,
	input wire logic write_high_strobe_n,
	input wire logic ready_busy_n
);
	// ****************************************
	// helper logic
	// ****************************************
	logic [CNT_W-1:0] busy_cnt_reg;
	logic st_rd_reg;
	logic tog_reg;
	logic seen_reg;
	wire write_seen = !wr_n || !write_low_strobe_n || !write_high_strobe_n;
	// seen_reg drops between busy periods so toggle is only compared inside one operation
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			busy_cnt_reg <= CNT_ZERO;
			st_rd_reg <= 1'b0;
			tog_reg <= 1'b0;
			seen_reg <= 1'b0;
		end else begin
			busy_cnt_reg <= ready_busy_n ? CNT_ZERO : busy_cnt_reg + 8'h01;
			st_rd_reg <= !rd_n && !ready_busy_n;
			tog_reg <= st_rd_reg ? rdata[TOGGLE_BIT] : tog_reg;
			seen_reg <= st_rd_reg || (seen_reg && !ready_busy_n);
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);
	chk_reset_idle: assert property ($fell(rst_in) |-> ready_busy_n && rd_n && wr_n)
		else $error("bus not idle after reset");
	chk_rd_pulse: assert property (!rd_n |=> rd_n)
		else $error("read strobe longer than one cycle");
	chk_no_overlap: assert property (!rd_n |-> !write_seen)
		else $error("read and write in one cycle");
	chk_no_write_busy: assert property (!ready_busy_n |-> !write_seen)
		else $error("write while device busy");
	chk_busy_start: assert property ($fell(ready_busy_n) |-> $past(write_seen))
		else $error("busy without a final write");
	chk_busy_len: assert property ($rose(ready_busy_n) |->
		busy_cnt_reg inside {PROG_CYC, PROG_TIMEOUT_CYC, ERASE_CYC, PROT_TIMEOUT_CYC})
		else $error("busy period of wrong length");
	chk_toggle_flip: assert property (st_rd_reg && seen_reg |-> rdata[TOGGLE_BIT] != tog_reg)
		else $error("toggle bit did not flip");
	chk_erase_poll: assert property (st_rd_reg && rdata[ETO_BIT] |->
		!rdata[POLL_BIT] && !rdata[ERR_BIT])
		else $error("erase status poll or error bit set");
	chk_rdata_hold: assert property ($past(rd_n) |-> $stable(rdata))
		else $error("read data changed without a read");
endmodule : flash_bus_properties

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top import flash_pkg::*;;
	typedef struct packed {
		logic wm;
		logic [1:0] lm;
		logic [2:0] op;
		logic [7:0] a;
		logic [15:0] d;
		logic [1:0] ln;
		logic [15:0] e;
	} row_s;
	row_s rows [0:13];
	logic ref_clk_in, rst_in, ce_in, word_mode, cmd_valid, cmd_ready, done, fail, busy, error;
	logic [1:0] lane_mode, cmd_lanes;
	logic [3:0] protect;
	logic [2:0] cmd_op;
	logic [7:0] cmd_addr;
	logic [15:0] cmd_data, rdata;
	int miscompares = 0;
	int total_checks = 0;
	flash_bus_if i_flash_bus_if ();
	flash_device i_flash_device (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.word_mode_in(word_mode), .lane_mode_in(lane_mode), .protect_in(protect),
		.busy_out(busy), .error_out(error), .bus(i_flash_bus_if));
	flash_host i_flash_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.word_mode_in(word_mode), .lane_mode_in(lane_mode), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
		.cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .cmd_lanes_in(cmd_lanes), .cmd_ready_out(cmd_ready),
		.done_out(done), .fail_out(fail), .rdata_out(rdata), .bus(i_flash_bus_if));
	flash_bus_properties i_flash_bus_properties (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.addr(i_flash_bus_if.addr), .wdata(i_flash_bus_if.wdata), .rdata(i_flash_bus_if.rdata),
		.rd_n(i_flash_bus_if.rd_n), .wr_n(i_flash_bus_if.wr_n),
		.byte_high_enable_n(i_flash_bus_if.byte_high_enable_n),
		.write_low_strobe_n(i_flash_bus_if.write_low_strobe_n),
		.write_high_strobe_n(i_flash_bus_if.write_high_strobe_n),
		.ready_busy_n(i_flash_bus_if.ready_busy_n));
	// ****************************************
	// tasks
	// ****************************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask : cmp_bit
	task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_word
	// polls share no timeout in the host, so the bench bounds every wait itself
	task automatic run_cmd(input logic [2:0] op, input logic [7:0] a, input logic [15:0] d, input logic [1:0] ln);
		int n;
		n = 0;
		@(negedge ref_clk_in);
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge ref_clk_in);
			n++;
		end
		@(posedge ref_clk_in);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= d;
		cmd_lanes <= ln;
		@(posedge ref_clk_in);
		cmd_valid <= 1'b0;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (done !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			miscompares++;
			$display("Error done expected 1 seen %b", done);
			close_out();
		end
	endtask : run_cmd
	initial begin
		ref_clk_in = 1'b0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst_in = 1'b1;
		ce_in = 1'b1;
		word_mode = 1'b1;
		lane_mode = LANE_NONE;
		protect = 4'h0;
		cmd_valid = 1'b0;
		cmd_op = OP_READ;
		cmd_addr = 8'h00;
		cmd_data = 16'h0000;
		cmd_lanes = 2'h0;
		rows = '{'{1'b1, LANE_NONE, OP_PROGRAM, 8'h10, 16'h1234, 2'h3, 16'h0000},
			'{1'b1, LANE_NONE, OP_READ, 8'h11, 16'h0000, 2'h0, 16'h1234},
			'{1'b1, LANE_BHE, OP_PROGRAM, 8'h21, 16'hab00, 2'h2, 16'h0000},
			'{1'b1, LANE_BHE, OP_PROGRAM, 8'h20, 16'h0056, 2'h1, 16'h0000},
			'{1'b1, LANE_BHE, OP_READ, 8'h21, 16'h0000, 2'h0, 16'hab56},
			'{1'b1, LANE_STROBES, OP_PROGRAM, 8'h30, 16'hc300, 2'h2, 16'h0000},
			'{1'b1, LANE_STROBES, OP_PROGRAM, 8'h30, 16'h0011, 2'h1, 16'h0000},
			'{1'b1, LANE_STROBES, OP_READ, 8'h30, 16'h0000, 2'h0, 16'hc311},
			'{1'b1, LANE_NONE, OP_PROGRAM, 8'h10, 16'h0230, 2'h3, 16'h0000},
			'{1'b1, LANE_NONE, OP_READ, 8'h10, 16'h0000, 2'h0, 16'h0230},
			'{1'b0, LANE_NONE, OP_PROGRAM, 8'h41, 16'h005a, 2'h0, 16'h0000},
			'{1'b0, LANE_NONE, OP_PROGRAM, 8'h40, 16'h0012, 2'h0, 16'h0000},
			'{1'b0, LANE_NONE, OP_READ, 8'h40, 16'h0000, 2'h0, 16'h0012},
			'{1'b0, LANE_NONE, OP_READ, 8'h41, 16'h0000, 2'h0, 16'h005a}};
		repeat (4) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		run_cmd(OP_BULK_ERASE, 8'h00, 16'h0000, 2'h0);
		cmp_bit("erase fail", 1'b0, fail); // whole array
		for (int i = 0; i < 14; i++) begin
			@(posedge ref_clk_in);
			word_mode <= rows[i].wm;
			lane_mode <= rows[i].lm;
			run_cmd(rows[i].op, rows[i].a, rows[i].d, rows[i].ln);
			if (rows[i].op == OP_READ)
				cmp_word("read data", rows[i].e, rdata);
			else
				cmp_bit("program fail", 1'b0, fail);
		end
		$display("test table done");
		@(posedge ref_clk_in);
		word_mode <= 1'b1;
		lane_mode <= LANE_NONE;
		protect <= 4'h2;
		// poll bit matches the erased word, so only the verify read shows the write was dropped
		run_cmd(OP_PROGRAM, 8'h50, 16'h00ff, 2'h3);
		cmp_bit("program fail", 1'b1, fail); // verify mismatch
		cmp_bit("error flag", 1'b0, error); // protected sector
		run_cmd(OP_READ, 8'h50, 16'h0000, 2'h0);
		cmp_word("protected word", 16'hffff, rdata); // contents kept
		@(posedge ref_clk_in);
		protect <= 4'h0;
		$display("test protect done");
		run_cmd(OP_PROGRAM, 8'h10, 16'hffff, 2'h3);
		cmp_bit("program fail", 1'b1, fail); // one over zero
		cmp_bit("busy", 1'b1, busy); // timeout still running
		// the timed-out program stays busy; a reset write before it ends would be ignored
		repeat (60) @(negedge ref_clk_in);
		cmp_bit("busy", 1'b0, busy); // holding is not busy
		cmp_bit("error flag", 1'b1, error); // sticky
		run_cmd(OP_RESET, 8'h00, 16'h0000, 2'h0);
		@(negedge ref_clk_in);
		cmp_bit("error flag", 1'b0, error); // cleared by command
		run_cmd(OP_READ, 8'h10, 16'h0000, 2'h0);
		cmp_word("word after error", 16'h0230, rdata); // no bit set back
		$display("test error done");
		run_cmd(OP_SECTOR_ERASE, 8'h20, 16'h0000, 2'h0);
		cmp_bit("erase fail", 1'b0, fail); // sector erase
		run_cmd(OP_READ, 8'h10, 16'h0000, 2'h0);
		cmp_word("erased word", 16'hffff, rdata); // sector cleared
		run_cmd(OP_READ, 8'h40, 16'h0000, 2'h0);
		cmp_word("other sector", 16'h5a12, rdata); // other sector kept
		$display("test erase done");
		@(posedge ref_clk_in);
		rst_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(negedge ref_clk_in);
		cmp_bit("busy", 1'b0, busy); // ready after reset
		cmp_bit("error flag", 1'b0, error); // cleared by reset
		cmp_bit("host ready", 1'b1, cmd_ready); // idle host
		run_cmd(OP_READ, 8'h40, 16'h0000, 2'h0);
		cmp_word("array after reset", 16'h5a12, rdata); // read mode
		$display("test reset done");
		close_out();
	end
endmodule : tb_top

// ===== hdl/flash_device.sv
`timescale 1ns/1ps
module flash_device import flash_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic word_mode_in,
	input wire logic [1:0] lane_mode_in,
	input wire logic [SECTORS-1:0] protect_in,
	output logic busy_out,
	output logic error_out,
	flash_bus_if.device bus
);
	// ****************************************
	// states
	// ****************************************
	typedef enum logic [9:0] {
		ST_READ = 10'b00_0000_0001,
		ST_UNLOCK1 = 10'b00_0000_0010,
		ST_UNLOCK2 = 10'b00_0000_0100,
		ST_PROG_SETUP = 10'b00_0000_1000,
		ST_ERASE_SETUP = 10'b00_0001_0000,
		ST_ERASE_UNLOCK1 = 10'b00_0010_0000,
		ST_ERASE_UNLOCK2 = 10'b00_0100_0000,
		ST_PROGRAM = 10'b00_1000_0000,
		ST_ERASE = 10'b01_0000_0000,
		ST_HOLD = 10'b10_0000_0000
	} dev_state_e;

	dev_state_e state_reg, state_next;
	logic [BYTE_W-1:0] lo_mem [WORDS];
	logic [BYTE_W-1:0] hi_mem [WORDS];
	logic [WORD_AW-1:0] tgt_idx_reg;
	logic [BYTE_W-1:0] tgt_lo_reg, tgt_hi_reg;
	logic tgt_lo_en_reg, tgt_hi_en_reg, tgt_bit7_reg, bad_reg;
	logic [SECTORS-1:0] er_mask_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic err_reg, toggle_reg, busy_reg, ready_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [BYTE_W-1:0] status;

	// ****************************************
	// write decode and lane selection
	// ****************************************
	wire a0 = bus.addr[0];
	wire strobe_mode = word_mode_in && (lane_mode_in == LANE_STROBES);
	wire bhe_mode = word_mode_in && (lane_mode_in == LANE_BHE);
	wire wr_evt = strobe_mode ? (!bus.write_low_strobe_n || !bus.write_high_strobe_n) : !bus.wr_n;
	wire rd_evt = !bus.rd_n;
	// 8-bit: A0 picks the byte; 16-bit plain: always the whole word
	wire lo_en = !word_mode_in ? !a0 : bhe_mode ? !a0 : strobe_mode ? !bus.write_low_strobe_n : 1'b1;
	wire hi_en = !word_mode_in ? a0 : bhe_mode ? !bus.byte_high_enable_n :
		strobe_mode ? !bus.write_high_strobe_n : 1'b1;
	wire [BYTE_W-1:0] lo_byte = bus.wdata[BYTE_W-1:0];
	wire [BYTE_W-1:0] hi_byte = word_mode_in ? bus.wdata[DATA_W-1:BYTE_W] : bus.wdata[BYTE_W-1:0];
	wire [BYTE_W-1:0] cmd_byte = lo_en ? lo_byte : hi_byte;
	wire [WORD_AW-1:0] widx = bus.addr[ADDR_W-1:1];
	wire [SECT_W-1:0] wsect = widx[WORD_AW-1 -: SECT_W];
	wire is_u1 = bus.addr == UNLOCK1_ADDR;
	wire is_u2 = bus.addr == UNLOCK2_ADDR;
	wire [BYTE_W-1:0] old_lo = lo_mem[widx];
	wire [BYTE_W-1:0] old_hi = hi_mem[widx];
	wire bad_bits = (lo_en && |(lo_byte & ~old_lo)) || (hi_en && |(hi_byte & ~old_hi));
	wire cmd_reset = wr_evt && (cmd_byte == CMD_RESET);
	wire is_bulk = is_u1 && (cmd_byte == CMD_BULK);
	wire [SECTORS-1:0] er_mask = (is_bulk ? {SECTORS{1'b1}} : (SECTORS'(1) << wsect)) & ~protect_in;
	wire enter_prog = (state_reg == ST_PROG_SETUP) && (state_next == ST_PROGRAM);
	wire enter_erase = (state_reg == ST_ERASE_UNLOCK2) && (state_next == ST_ERASE);
	wire cnt_done = cnt_reg == CNT_ZERO;
	wire prog_ok_done = (state_reg == ST_PROGRAM) && cnt_done && !bad_reg;
	wire erase_done = (state_reg == ST_ERASE) && cnt_done;
	wire prog_side = (state_reg == ST_PROGRAM) || (state_reg == ST_HOLD);
	wire in_alg = prog_side || (state_reg == ST_ERASE);
	wire er_hit = (er_mask_reg == '0) || er_mask_reg[wsect];
	wire status_hit = prog_side ? (widx == tgt_idx_reg) : (state_reg == ST_ERASE) && er_hit;
	wire err_set = (enter_prog && bad_bits) || ((state_reg == ST_PROGRAM) && cnt_done && bad_reg);
	wire err_clr = cmd_reset && !in_alg || cmd_reset && (state_reg == ST_HOLD);
	wire busy_next = (state_next == ST_PROGRAM) || (state_next == ST_ERASE);
	wire [BYTE_W-1:0] arr_byte = a0 ? old_hi : old_lo;
	wire [DATA_W-1:0] arr_word = word_mode_in ? {old_hi, old_lo} : {ZERO_BYTE, arr_byte};
	wire [DATA_W-1:0] stat_word = word_mode_in ? {status, status} : {ZERO_BYTE, status};

	// ****************************************
	// status byte
	// ****************************************
	always_comb begin
		status = ZERO_BYTE;
		status[POLL_BIT] = prog_side ? !tgt_bit7_reg : 1'b0;
		status[TOGGLE_BIT] = toggle_reg;
		status[ERR_BIT] = err_reg;
		status[ETO_BIT] = state_reg == ST_ERASE;
	end

	// ****************************************
	// command sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_READ: begin
				if (wr_evt && is_u1 && (cmd_byte == CMD_UNLOCK1)) begin
					state_next = ST_UNLOCK1;
				end
			end
			ST_UNLOCK1: begin
				if (wr_evt) begin
					state_next = (is_u2 && (cmd_byte == CMD_UNLOCK2)) ? ST_UNLOCK2 : ST_READ;
				end
			end
			ST_UNLOCK2: begin
				if (wr_evt) begin
					state_next = !is_u1 ? ST_READ : (cmd_byte == CMD_PROGRAM) ? ST_PROG_SETUP :
						(cmd_byte == CMD_ERASE) ? ST_ERASE_SETUP : ST_READ;
				end
			end
			ST_PROG_SETUP: begin
				if (wr_evt) begin
					state_next = protect_in[wsect] ? ST_READ : ST_PROGRAM;
				end
			end
			ST_ERASE_SETUP: begin
				if (wr_evt) begin
					state_next = (is_u1 && (cmd_byte == CMD_UNLOCK1)) ? ST_ERASE_UNLOCK1 : ST_READ;
				end
			end
			ST_ERASE_UNLOCK1: begin
				if (wr_evt) begin
					state_next = (is_u2 && (cmd_byte == CMD_UNLOCK2)) ? ST_ERASE_UNLOCK2 : ST_READ;
				end
			end
			ST_ERASE_UNLOCK2: begin
				if (wr_evt) begin
					state_next = ((cmd_byte == CMD_SECTOR) || is_bulk) ? ST_ERASE : ST_READ;
				end
			end
			ST_PROGRAM: begin
				if (cnt_done) begin
					state_next = bad_reg ? ST_HOLD : ST_READ;
				end
			end
			ST_ERASE: begin
				if (cnt_done) begin
					state_next = ST_READ;
				end
			end
			ST_HOLD: begin
				if (cmd_reset) begin
					state_next = ST_READ;
				end
			end
			default: state_next = ST_READ;
		endcase
	end

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_reg <= ST_READ;
			cnt_reg <= CNT_ZERO;
			err_reg <= 1'b0;
			toggle_reg <= 1'b0;
			busy_reg <= 1'b0;
			ready_reg <= 1'b1;
			rdata_reg <= '0;
		end else if (ce_in) begin
			state_reg <= state_next;
			// set wins over a clear arriving in the same cycle
			err_reg <= err_set ? 1'b1 : err_clr ? 1'b0 : err_reg;
			busy_reg <= busy_next;
			ready_reg <= !busy_next;
			if (enter_prog) begin
				cnt_reg <= bad_bits ? PROG_TIMEOUT_LOAD : PROG_LOAD;
			end else if (enter_erase) begin
				cnt_reg <= (er_mask == '0) ? PROT_TIMEOUT_LOAD : ERASE_LOAD;
			end else if (!cnt_done) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
			if (rd_evt && status_hit) begin
				toggle_reg <= !toggle_reg;
			end
			if (rd_evt) begin
				rdata_reg <= status_hit ? stat_word : arr_word;
			end
		end
	end

	// target capture needs no reset: it is only read while the algorithm runs
	always_ff @(posedge ref_clk_in) begin
		if (ce_in && enter_prog) begin
			tgt_idx_reg <= widx;
			tgt_lo_reg <= lo_byte;
			tgt_hi_reg <= hi_byte;
			tgt_lo_en_reg <= lo_en;
			tgt_hi_en_reg <= hi_en;
			tgt_bit7_reg <= lo_en ? lo_byte[BYTE_W-1] : hi_byte[BYTE_W-1];
			bad_reg <= bad_bits;
		end
		if (ce_in && enter_erase) begin
			er_mask_reg <= er_mask;
		end
	end

	// ****************************************
	// array: survives reset like real flash
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (ce_in && prog_ok_done) begin
			if (tgt_lo_en_reg) begin
				lo_mem[tgt_idx_reg] <= lo_mem[tgt_idx_reg] & tgt_lo_reg;
			end
			if (tgt_hi_en_reg) begin
				hi_mem[tgt_idx_reg] <= hi_mem[tgt_idx_reg] & tgt_hi_reg;
			end
		end
		if (ce_in && erase_done) begin
			for (int i = 0; i < WORDS; i++) begin
				if (er_mask_reg[i / (WORDS / SECTORS)]) begin
					lo_mem[i] <= ERASED_BYTE;
					hi_mem[i] <= ERASED_BYTE;
				end
			end
		end
	end

	assign bus.rdata = rdata_reg;
	// own flop so the pin leaves straight from a register, not through an inverter
	assign bus.ready_busy_n = ready_reg;
	assign busy_out = busy_reg;
	assign error_out = err_reg;
endmodule : flash_device

// ===== hdl/flash_host.sv
`timescale 1ns/1ps
module flash_host import flash_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic word_mode_in,
	input wire logic [1:0] lane_mode_in,
	input wire logic cmd_valid_in,
	input wire logic [2:0] cmd_op_in,
	input wire logic [ADDR_W-1:0] cmd_addr_in,
	input wire logic [DATA_W-1:0] cmd_data_in,
	input wire logic [1:0] cmd_lanes_in,
	output logic cmd_ready_out,
	output logic done_out,
	output logic fail_out,
	output logic [DATA_W-1:0] rdata_out,
	flash_bus_if.host bus
);
	typedef enum logic [4:0] {
		H_IDLE = 5'b0_0001,
		H_WRITE = 5'b0_0010,
		H_RD = 5'b0_0100,
		H_WAIT = 5'b0_1000,
		H_CHK = 5'b1_0000
	} host_state_e;

	host_state_e state_reg;
	logic [2:0] op_reg, step_reg;
	logic [ADDR_W-1:0] addr_reg, bus_addr_reg;
	logic [DATA_W-1:0] data_reg, wdata_reg, rdata_reg;
	logic [1:0] lanes_reg;
	logic polling_reg, reread_reg, done_reg, fail_reg;
	logic rd_n_reg, wr_n_reg, bhe_n_reg, wrl_n_reg, wrh_n_reg;

	// ****************************************
	// step table and lane choice
	// ****************************************
	wire is_prog = op_reg == OP_PROGRAM;
	wire [2:0] last_step = (op_reg == OP_RESET) ? 3'h0 : is_prog ? STEP_PROG_LAST : STEP_ERASE_LAST;
	wire data_step = is_prog && (step_reg == STEP_PROG_LAST);
	wire final_step = step_reg == last_step;
	wire u2_step = (step_reg == 3'h1) || (step_reg == 3'h4);
	wire [BYTE_W-1:0] cmd_byte = (op_reg == OP_RESET) ? CMD_RESET :
		(step_reg == 3'h2) ? (is_prog ? CMD_PROGRAM : CMD_ERASE) :
		u2_step ? CMD_UNLOCK2 : (step_reg == STEP_ERASE_LAST) ?
		((op_reg == OP_BULK_ERASE) ? CMD_BULK : CMD_SECTOR) : CMD_UNLOCK1;
	wire sect_step = (step_reg == STEP_ERASE_LAST) && (op_reg == OP_SECTOR_ERASE);
	wire [ADDR_W-1:0] step_addr = (data_step || sect_step) ? addr_reg : u2_step ? UNLOCK2_ADDR : UNLOCK1_ADDR;
	wire lo_w = !data_step || !word_mode_in || lanes_reg[0];
	wire hi_w = !data_step || !word_mode_in || lanes_reg[1];
	wire bhe_mode = word_mode_in && (lane_mode_in == LANE_BHE);
	// plain 16-bit writes whole words, so the address is forced even
	wire w_a0 = !word_mode_in ? step_addr[0] : (bhe_mode && !lo_w);
	wire [ADDR_W-1:0] even_addr = {addr_reg[ADDR_W-1:1], 1'b0};
	wire [ADDR_W-1:0] rd_addr = word_mode_in ? even_addr : addr_reg;
	wire [BYTE_W-1:0] stat = bus.rdata[BYTE_W-1:0];
	wire exp7 = !is_prog ? 1'b1 : (word_mode_in && !lanes_reg[0]) ? data_reg[DATA_W-1] : data_reg[BYTE_W-1];
	wire poll_match = stat[POLL_BIT] == exp7;
	wire lo_ok = !lanes_reg[0] && word_mode_in || bus.rdata[BYTE_W-1:0] == data_reg[BYTE_W-1:0];
	wire hi_ok = !word_mode_in || !lanes_reg[1] || bus.rdata[DATA_W-1:BYTE_W] == data_reg[DATA_W-1:BYTE_W];
	wire chk_done = !polling_reg || poll_match && !is_prog || !poll_match && stat[ERR_BIT] && reread_reg;
	wire chk_fail = polling_reg ? !poll_match : (is_prog && !(lo_ok && hi_ok));

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_reg <= H_IDLE;
			{rd_n_reg, wr_n_reg, bhe_n_reg, wrl_n_reg, wrh_n_reg} <= 5'h1f;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			rdata_reg <= '0;
			bus_addr_reg <= '0;
			wdata_reg <= '0;
		end else if (ce_in) begin
			{rd_n_reg, wr_n_reg, bhe_n_reg, wrl_n_reg, wrh_n_reg} <= 5'h1f;
			done_reg <= 1'b0;
			unique case (state_reg)
				H_IDLE: begin
					if (cmd_valid_in) begin
						op_reg <= cmd_op_in;
						addr_reg <= cmd_addr_in;
						data_reg <= cmd_data_in;
						lanes_reg <= cmd_lanes_in;
						step_reg <= 3'h0;
						polling_reg <= cmd_op_in != OP_READ;
						reread_reg <= 1'b0;
						state_reg <= (cmd_op_in == OP_READ) ? H_RD : H_WRITE;
					end
				end
				H_WRITE: begin
					bus_addr_reg <= {step_addr[ADDR_W-1:1], w_a0};
					wdata_reg <= data_step ? (word_mode_in ? data_reg : {ZERO_BYTE, data_reg[BYTE_W-1:0]}) :
						{ZERO_BYTE, cmd_byte};
					wr_n_reg <= 1'b0;
					bhe_n_reg <= !hi_w;
					wrl_n_reg <= !lo_w;
					wrh_n_reg <= !hi_w;
					step_reg <= step_reg + 3'h1;
					if (final_step) begin
						done_reg <= op_reg == OP_RESET;
						fail_reg <= 1'b0;
						state_reg <= (op_reg == OP_RESET) ? H_IDLE : H_RD;
					end
				end
				H_RD: begin
					bus_addr_reg <= rd_addr;
					rd_n_reg <= 1'b0;
					state_reg <= H_WAIT;
				end
				H_WAIT: state_reg <= H_CHK;
				H_CHK: begin
					state_reg <= chk_done ? H_IDLE : H_RD;
					done_reg <= chk_done;
					fail_reg <= chk_fail;
					rdata_reg <= bus.rdata;
					if (polling_reg && poll_match) begin
						polling_reg <= 1'b0;
					end
					if (polling_reg && !poll_match && stat[ERR_BIT]) begin
						reread_reg <= 1'b1;
					end
				end
			endcase
		end
	end

	assign bus.addr = bus_addr_reg;
	assign bus.wdata = wdata_reg;
	assign bus.rd_n = rd_n_reg;
	assign bus.wr_n = wr_n_reg;
	assign bus.byte_high_enable_n = bhe_n_reg;
	assign bus.write_low_strobe_n = wrl_n_reg;
	assign bus.write_high_strobe_n = wrh_n_reg;
	assign cmd_ready_out = state_reg == H_IDLE;
	assign done_out = done_reg;
	assign fail_out = fail_reg;
	assign rdata_out = rdata_reg;
endmodule : flash_host

// ===== include/flash_bus_if.sv
`timescale 1ns/1ps
interface flash_bus_if import flash_pkg::*;;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	logic rd_n;
	logic wr_n;
	logic byte_high_enable_n;
	logic write_low_strobe_n;
	logic write_high_strobe_n;
	logic ready_busy_n;
	modport device(input addr, input wdata, input rd_n, input wr_n, input byte_high_enable_n,
		input write_low_strobe_n, input write_high_strobe_n, output rdata, output ready_busy_n);
	modport host(output addr, output wdata, output rd_n, output wr_n, output byte_high_enable_n,
		output write_low_strobe_n, output write_high_strobe_n, input rdata, input ready_busy_n);
endinterface : flash_bus_if

// ===== include/flash_pkg.sv
package flash_pkg;
	// ****************************************
	// bus geometry
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int WORD_AW = ADDR_W - 1;
	localparam int WORDS = 1 << WORD_AW;
	localparam int SECT_W = 2;
	localparam int SECTORS = 1 << SECT_W;
	localparam int CNT_W = 8;
	// ****************************************
	// lane selection modes (16-bit configuration only)
	// ****************************************
	localparam logic [1:0] LANE_NONE = 2'h0;
	localparam logic [1:0] LANE_BHE = 2'h1;
	localparam logic [1:0] LANE_STROBES = 2'h2;
	// ****************************************
	// command patterns
	// ****************************************
	localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 8'haa;
	localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 8'h54;
	localparam logic [BYTE_W-1:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [BYTE_W-1:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [BYTE_W-1:0] CMD_PROGRAM = 8'ha0;
	localparam logic [BYTE_W-1:0] CMD_ERASE = 8'h80;
	localparam logic [BYTE_W-1:0] CMD_SECTOR = 8'h30;
	localparam logic [BYTE_W-1:0] CMD_BULK = 8'h10;
	localparam logic [BYTE_W-1:0] CMD_RESET = 8'hf0;
	localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;
	localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
	// ****************************************
	// status byte layout
	// ****************************************
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int ERR_BIT = 5;
	localparam int ETO_BIT = 3;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_NS = 100;
	localparam int PROG_NS = 2000;
	localparam int PROG_TIMEOUT_NS = 5000;
	localparam int ERASE_NS = 10000;
	localparam int PROT_TIMEOUT_NS = 3000;
	localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_TIMEOUT_CYC = (PROG_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROT_TIMEOUT_CYC = (PROT_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [CNT_W-1:0] PROG_LOAD = CNT_W'(PROG_CYC - 1);
	localparam logic [CNT_W-1:0] PROG_TIMEOUT_LOAD = CNT_W'(PROG_TIMEOUT_CYC - 1);
	localparam logic [CNT_W-1:0] ERASE_LOAD = CNT_W'(ERASE_CYC - 1);
	localparam logic [CNT_W-1:0] PROT_TIMEOUT_LOAD = CNT_W'(PROT_TIMEOUT_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	// ****************************************
	// host operations
	// ****************************************
	localparam logic [2:0] OP_READ = 3'h0;
	localparam logic [2:0] OP_PROGRAM = 3'h1;
	localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
	localparam logic [2:0] OP_BULK_ERASE = 3'h3;
	localparam logic [2:0] OP_RESET = 3'h4;
	localparam logic [2:0] STEP_PROG_LAST = 3'h3;
	localparam logic [2:0] STEP_ERASE_LAST = 3'h5;
endpackage : flash_pkg
